// *** hdl/iab_core.sv ***
// Two-wire bus controller core covering arbitration, bus release and wait cancel.
//
// Chosen here: the address map and the Avalon-MM slave port.

// Summary of operation
// R1: Competing masters clock and compare until data differs.
// R2: Start trigger before start detect joins arbitration.
// R3: Loss sets flag and releases both lines.
// R4: Software reads loss flag at next interrupt.
// R5: Writing FFH or wait release ends wait.
// R6: Slave transmitter ends wait by writing data.
// R7: Wait release in slave transmit clears direction.
// R8: Start flags sit at bit 1 of registers.
// R9: Loss when released high data reads low.
module iab_core
    import iab_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Bus lines
    input wire logic bus_clock_line_i,
    output logic bus_clock_line_o,
    output logic bus_clock_line_oe_o,
    input wire logic bus_data_line_i,
    output logic bus_data_line_o,
    output logic bus_data_line_oe_o,
    // Slave-role strobes from the address-match logic
    input wire logic slave_sel_i,
    input wire logic slave_tx_i,
    // Interrupt
    output logic bus_interrupt_request_o
);
    import iab_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    iab_lines_t sync1, sync2, sync3, lines;
    logic [2:0] sel_sync;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= '{scl: 1'b1, sda: 1'b1};
            sync2 <= '{scl: 1'b1, sda: 1'b1};
            sync3 <= '{scl: 1'b1, sda: 1'b1};
            lines <= '{scl: 1'b1, sda: 1'b1};
            sel_sync <= 3'h0;
        end else begin
            sync1 <= '{scl: bus_clock_line_i, sda: bus_data_line_i};
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2.scl == sync3.scl) begin
                lines.scl <= sync3.scl;
            end
            if (sync2.sda == sync3.sda) begin
                lines.sda <= sync3.sda;
            end
            sel_sync <= {sel_sync[1:0], slave_sel_i};
        end
    end

    iab_lines_t prev;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            prev <= lines;
        end
    end

    wire scl_rise = lines.scl && !prev.scl;
    wire scl_fall = !lines.scl && prev.scl;
    wire start_seen = lines.scl && prev.scl && prev.sda && !lines.sda;
    wire stop_seen = lines.scl && prev.scl && !prev.sda && lines.sda;
    wire slave_sel = sel_sync[2];

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    wire wr_ctl = avs_write_i && (avs_address_i == OFS_CTL0);
    wire wr_stat = avs_write_i && (avs_address_i == OFS_STAT0);
    wire wr_data = avs_write_i && (avs_address_i == OFS_DATA);
    wire wr_mask = avs_write_i && (avs_address_i == OFS_IMASK);
    wire stt_req = wr_ctl && avs_writedata_i[CTL_STT_BIT];
    wire wrel_req = wr_ctl && avs_writedata_i[CTL_WREL_BIT];
    wire cancel_ff = wr_data && (avs_writedata_i[7:0] == WAIT_CANCEL_VALUE);
    wire wait_cancel = wrel_req || wr_data; // see R5

    // ------------------------------------------------------------------
    // Bit engine
    // ------------------------------------------------------------------
    iab_role_t role;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic start_flag, ald_flag, trc_flag, waiting, drive_sda, scl_hold, stt_pend;
    logic [EV_WIDTH-1:0] ev_stat, ev_mask;

    wire lost = (role == IAB_MASTER) && scl_rise && !drive_sda && !lines.sda
                && bit_cnt < BYTE_BITS; // see R9
    wire byte_done = (role != IAB_IDLE) && scl_fall && bit_cnt == BYTE_BITS;
    wire [EV_WIDTH-1:0] ev_set = {stop_seen, byte_done, lost};

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            role <= IAB_IDLE;
            shreg <= DATA_RST;
            bit_cnt <= 4'h0;
            start_flag <= 1'b0;
            ald_flag <= 1'b0;
            trc_flag <= 1'b0;
            waiting <= 1'b0;
            drive_sda <= 1'b0;
            scl_hold <= 1'b0;
            stt_pend <= 1'b0;
        end else begin
            if (wr_data) begin
                shreg <= avs_writedata_i[7:0];
            end
            if (start_seen) begin
                start_flag <= 1'b1;
                bit_cnt <= 4'h0;
            end else if (stop_seen) begin
                start_flag <= 1'b0;
                role <= IAB_IDLE;
                scl_hold <= 1'b0;
                drive_sda <= 1'b0;
                waiting <= 1'b0;
            end
            // A trigger taken before the start is seen joins arbitration.
            if (stt_req && !start_flag) begin // see R2
                stt_pend <= 1'b1;
                drive_sda <= 1'b1;
                role <= IAB_MASTER;
                trc_flag <= 1'b1;
            end
            if (start_seen && stt_pend) begin
                stt_pend <= 1'b0;
            end
            if (slave_sel && role == IAB_IDLE && start_flag) begin
                role <= IAB_SLAVE;
                trc_flag <= slave_tx_i;
            end
            // Each bit is compared on the high phase until a loser drops out.
            if (lost) begin // see R1
                ald_flag <= 1'b1; // see R3
                role <= IAB_IDLE;
                drive_sda <= 1'b0; // see R3
                scl_hold <= 1'b0;
                trc_flag <= 1'b0;
            end else if (scl_rise && role != IAB_IDLE && bit_cnt < BYTE_BITS) begin
                shreg <= {shreg[6:0], lines.sda};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && role != IAB_IDLE && bit_cnt < BYTE_BITS) begin
                drive_sda <= trc_flag && !shreg[7];
            end
            if (byte_done) begin
                waiting <= 1'b1;
                scl_hold <= 1'b1;
                bit_cnt <= 4'h0;
            end else if (waiting && wait_cancel) begin // see R5
                waiting <= 1'b0;
                scl_hold <= 1'b0;
                if (wrel_req && role == IAB_SLAVE) begin
                    trc_flag <= 1'b0; // see R7
                end
                if (cancel_ff) begin
                    drive_sda <= 1'b0;
                end
            end
            if (wr_stat && avs_writedata_i[ST_ALD_BIT] && !lost) begin
                ald_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status; a new event wins over a clear in the same cycle.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ev_stat <= '0;
            ev_mask <= IMASK_RST;
        end else begin
            ev_stat <= (ev_stat & ~({EV_WIDTH{wr_stat}} & avs_writedata_i[8+:EV_WIDTH]))
                       | ev_set; // see R4
            if (wr_mask) begin
                ev_mask <= avs_writedata_i[EV_WIDTH-1:0];
            end
        end
    end

    assign bus_interrupt_request_o = |(ev_stat & ev_mask);

    // ------------------------------------------------------------------
    // Line drivers: open drain, enable only while pulling low.
    // ------------------------------------------------------------------
    assign bus_clock_line_o = 1'b0;
    assign bus_clock_line_oe_o = scl_hold;
    assign bus_data_line_o = 1'b0;
    assign bus_data_line_oe_o = drive_sda;

    // ------------------------------------------------------------------
    // Read path, zero-wait single-cycle answer
    // ------------------------------------------------------------------
    logic [31:0] rdata;
    always_comb begin
        rdata = RDATA_ZERO;
        unique case (avs_address_i)
            OFS_CTL0: rdata[CTL_STT_BIT] = stt_pend; // see R8
            OFS_STAT0: begin
                rdata[ST_ALD_BIT] = ald_flag;
                rdata[ST_STD_BIT] = start_flag; // see R8
                rdata[ST_TRC_BIT] = trc_flag;
                rdata[ST_WAIT_BIT] = waiting;
                rdata[ST_BUSY_BIT] = role != IAB_IDLE;
                rdata[8+:EV_WIDTH] = ev_stat;
            end
            OFS_DATA: rdata[7:0] = shreg;
            OFS_IMASK: rdata[EV_WIDTH-1:0] = ev_mask;
            default: rdata = RDATA_ZERO;
        endcase
    end

    assign avs_readdata_o = rdata;
    assign avs_waitrequest_o = 1'b0;

endmodule // iab_core

// *** hdl/iab_pkg.sv ***
// Package with register map, field positions and shared types of the arbitration block.
package iab_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_CTL0 = 4'h0;
    localparam logic [3:0] OFS_STAT0 = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_IMASK = 4'hC;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_WREL_BIT = 0;
    localparam int CTL_STT_BIT = 1;
    localparam int ST_ALD_BIT = 0;
    localparam int ST_STD_BIT = 1;
    localparam int ST_TRC_BIT = 2;
    localparam int ST_WAIT_BIT = 3;
    localparam int ST_BUSY_BIT = 4;
    localparam int EV_ALD_BIT = 0;
    localparam int EV_BYTE_BIT = 1;
    localparam int EV_STOP_BIT = 2;
    localparam int EV_WIDTH = 3;

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'hFF;
    localparam logic [7:0] WAIT_CANCEL_VALUE = 8'hFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [EV_WIDTH-1:0] IMASK_RST = 3'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Sampled bus lines travel together.
    typedef struct packed {
        logic scl;
        logic sda;
    } iab_lines_t;

    typedef enum logic [1:0] {
        IAB_IDLE,
        IAB_MASTER,
        IAB_SLAVE
    } iab_role_t;

endpackage

// *** test/iab_core_assertions.sv ***
// Port-level checker of the arbitration core, bound into every core instance.
module iab_core_chk
    import iab_pkg::*;
(
    // Clock, reset and register bus
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Bus lines and interrupt
    input wire logic bus_clock_line_o,
    input wire logic bus_clock_line_oe_o,
    input wire logic bus_data_line_o,
    input wire logic bus_data_line_oe_o,
    input wire logic bus_interrupt_request_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mirror of the mask so the interrupt can be tied to it.
    logic [2:0] mask_q;
    wire mask_wr = avs_write_i && avs_address_i == OFS_IMASK;
    wire mapped = avs_address_i[1:0] == 2'h0;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) mask_q <= IMASK_RST;
        else if (mask_wr) mask_q <= avs_writedata_i[2:0];
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_held; bus_clock_line_oe_o; endsequence
    sequence s_wrel; avs_write_i && avs_address_i == OFS_CTL0 && avs_writedata_i[CTL_WREL_BIT];
    endsequence
    sequence s_dwr; avs_write_i && avs_address_i == OFS_DATA; endsequence
    a_no_wait: assert property ((avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest raised");
    a_open_drain: assert property (!bus_clock_line_o && !bus_data_line_o)
        else $error("line driven high");
    a_unmapped_zero: assert property (avs_read_i && !mapped |-> avs_readdata_o == RDATA_ZERO)
        else $error("unmapped read not zero");
    a_status_pad: assert property (avs_read_i && avs_address_i == OFS_STAT0 |->
        avs_readdata_o[31:11] == 21'h0 && avs_readdata_o[7:5] == 3'h0) else $error("status pad");
    a_mask_read: assert property (avs_read_i && avs_address_i == OFS_IMASK |->
        avs_readdata_o == {29'h0, mask_q}) else $error("mask readback");
    a_mask_off: assert property (mask_wr && avs_writedata_i[2:0] == 3'h0 |=>
        !bus_interrupt_request_o) else $error("irq with zero mask");
    a_irq_masked: assert property (bus_interrupt_request_o |-> mask_q != 3'h0)
        else $error("irq while masked");
    a_wrel_frees: assert property (s_held ##0 s_wrel |-> ##[1:3] !bus_clock_line_oe_o)
        else $error("wait release ignored");
    a_data_frees: assert property (s_held ##0 s_dwr |-> ##[1:3] !bus_clock_line_oe_o)
        else $error("data write kept wait");
    a_ff_release: assert property (s_dwr ##0 (avs_writedata_i[7:0] == WAIT_CANCEL_VALUE)
        |-> ##[1:3] !bus_data_line_oe_o) else $error("data line kept");
    a_reset_quiet: assert property ($rose(nrst_i) |->
        !bus_clock_line_oe_o && !bus_data_line_oe_o && !bus_interrupt_request_o)
        else $error("active after reset");
endmodule // iab_core_chk

bind iab_core iab_core_chk u_chk (.*);

// *** test/iab_core_tb.sv ***
// Self-checking bench of the arbitration and wait-release core.
module iab_core_tb;
    import iab_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, nrst_i, avs_read_i, avs_write_i, slave_sel_i, slave_tx_i;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, r;
    logic avs_waitrequest_o, bus_clock_line_o, bus_clock_line_oe_o, bus_data_line_o;
    logic bus_data_line_oe_o, bus_interrupt_request_o, far_scl_oe, far_sda_oe;
    int n_mismatch = 0;
    int checks = 0;
    wire scl = !(bus_clock_line_oe_o || far_scl_oe);
    wire sda = !(bus_data_line_oe_o || far_sda_oe);
    iab_core dut (.sys_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .bus_clock_line_i(scl),
        .bus_clock_line_o, .bus_clock_line_oe_o, .bus_data_line_i(sda), .bus_data_line_o,
        .bus_data_line_oe_o, .slave_sel_i, .slave_tx_i, .bus_interrupt_request_o);
    iab_far_master far (.clk_i(sys_clk_i), .scl_i(scl), .scl_oe_o(far_scl_oe),
        .sda_oe_o(far_sda_oe));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end
    task conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Read data is taken at the edge where waitrequest is seen low.
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        r = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        acc(1'b0, a, 32'h0000_0000);
        chk(r & m, e, nm);
    endtask
    initial begin
        {nrst_i, avs_read_i, avs_write_i, slave_sel_i, slave_tx_i} = 5'h00;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0000_0000;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rdc(OFS_DATA, 32'hFFFF_FFFF, {24'h00_0000, DATA_RST}, "data reset");
        rdc(OFS_STAT0, 32'hFFFF_FFFF, 32'h0000_0000, "status reset");
        rdc(OFS_IMASK, 32'hFFFF_FFFF, 32'h0000_0000, "mask reset");
        rdc(4'h2, 32'hFFFF_FFFF, RDATA_ZERO, "unmapped");
        acc(1'b1, OFS_DATA, 32'h0000_00FF);
        acc(1'b1, OFS_CTL0, 32'h0000_0002);
        rdc(OFS_CTL0, 32'h0000_0002, 32'h0000_0002, "trigger pending");
        far.start_cond();
        rdc(OFS_STAT0, 32'h0000_0002, 32'h0000_0002, "start seen");
        far.clock_byte(9'h000);
        chk(32'({bus_clock_line_oe_o, bus_data_line_oe_o}), 32'h0, "released");
        rdc(OFS_STAT0, 32'h0000_0101, 32'h0000_0101, "loss flag");
        chk(32'(bus_interrupt_request_o), 32'h0, "irq masked");
        acc(1'b1, OFS_IMASK, 32'h0000_0001);
        #1 chk(32'(bus_interrupt_request_o), 32'h1, "irq on loss");
        acc(1'b1, OFS_IMASK, 32'h0000_0000);
        #1 chk(32'(bus_interrupt_request_o), 32'h0, "irq mask off");
        acc(1'b1, OFS_IMASK, 32'h0000_0001);
        #1 chk(32'(bus_interrupt_request_o), 32'h1, "irq unmasked");
        acc(1'b1, OFS_STAT0, 32'h0000_0101);
        #1 chk(32'(bus_interrupt_request_o), 32'h0, "irq cleared");
        rdc(OFS_STAT0, 32'h0000_0101, 32'h0000_0000, "loss cleared");
        far.stop_cond();
        slave_sel_i <= 1'b1;
        slave_tx_i <= 1'b1;
        far.start_cond();
        far.clock_byte(9'h1FF);
        far.release_lines();
        rdc(OFS_STAT0, 32'h0000_020C, 32'h0000_020C, "tx wait");
        chk(32'(bus_clock_line_oe_o), 32'h1, "clock held");
        acc(1'b1, OFS_CTL0, 32'h0000_0001);
        rdc(OFS_STAT0, 32'h0000_000C, 32'h0000_0000, "wait released");
        far.clock_byte(9'h1FF);
        far.release_lines();
        rdc(OFS_STAT0, 32'h0000_0008, 32'h0000_0008, "second wait");
        acc(1'b1, OFS_DATA, 32'h0000_00FF);
        rdc(OFS_STAT0, 32'h0000_0008, 32'h0000_0000, "data cancel");
        chk(32'(bus_clock_line_oe_o), 32'h0, "clock freed");
        far.stop_cond();
        conclude();
    end
endmodule // iab_core_tb

// *** test/iab_far_master.sv ***
// Behavioural far-side master that clocks the shared lines and sends bits.
module iab_far_master (
    // Clock and clock line level
    input wire logic clk_i,
    input wire logic scl_i,
    // Pull-low enables
    output logic scl_oe_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Half of an 80 ns bit period.
    task hold();
        repeat (5) @(posedge clk_i);
    endtask
    task start_cond();
        sda_oe_o <= 1'b1;
        hold();
        scl_oe_o <= 1'b1;
        hold();
    endtask
    task release_lines();
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
        hold();
    endtask
    task stop_cond();
        sda_oe_o <= 1'b1;
        hold();
        scl_oe_o <= 1'b0;
        hold();
        sda_oe_o <= 1'b0;
        hold();
    endtask
    // A stretched clock is waited for, but only for a bounded time.
    task clock_byte(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda_oe_o <= !b[i];
            hold();
            scl_oe_o <= 1'b0;
            for (int k = 0; k < 400 && !scl_i; k++) @(posedge clk_i);
            hold();
            scl_oe_o <= 1'b1;
        end
        sda_oe_o <= 1'b0;
        hold();
    endtask
endmodule // iab_far_master
